// *** design/tw_params.svh ***
// Register map, field positions and counts of the 8-bit waveform timer
`ifndef TW_PARAMS_SVH
`define TW_PARAMS_SVH
// Bus geometry
`define TW_ADDR_W      12
`define TW_DATA_W      32
// Register indices; byte address is four times the index
`define TW_IDX_FLAGS   8'h39
`define TW_IDX_MASK    8'h3a
`define TW_IDX_CTRL_A  8'h3b
`define TW_IDX_CTRL_B  8'h3c
`define TW_IDX_COUNT   8'h3d
`define TW_IDX_CMP_A   8'h3e
`define TW_IDX_CMP_B   8'h3f
// Control A fields
`define TW_CA_ACT_A    7:6
`define TW_CA_ACT_B    5:4
`define TW_CA_WML      1:0
// Control B fields
`define TW_CB_FORCE_A  7
`define TW_CB_FORCE_B  6
`define TW_CB_WMH      3
`define TW_CB_CS       2:0
// Counter values
`define TW_MAX         8'hff
`define TW_BOTTOM      8'h00
`define TW_ONE         8'h01
`define TW_RST8        8'h00
// Prescaler width and tap masks
`define TW_PRE_W       10
`define TW_PRE_ZERO    10'h000
`define TW_PRE_ONE     10'h001
`define TW_DIV8        10'h007
`define TW_DIV64       10'h03f
`define TW_DIV256      10'h0ff
`define TW_DIV1024     10'h3ff
// Output action codes
`define TW_ACT_OFF     2'b00
`define TW_ACT_TOG     2'b01
`define TW_ACT_CLR     2'b10
`define TW_ACT_SET     2'b11
`endif

// *** design/tw_pkg.sv ***
// Types shared by the 8-bit waveform timer
package tw_pkg;
  // Waveform mode as formed from control B and control A bits
  typedef enum logic [2:0] {
    TW_WM_NORMAL  = 3'b000,
    TW_WM_PC_MAX  = 3'b001,
    TW_WM_CTC     = 3'b010,
    TW_WM_FAST_MX = 3'b011,
    TW_WM_RSV4    = 3'b100,
    TW_WM_PC_A    = 3'b101,
    TW_WM_RSV6    = 3'b110,
    TW_WM_FAST_A  = 3'b111
  } tw_wave_mode_t;
  // Count direction state
  typedef enum logic {
    TW_DIR_UP   = 1'b0,
    TW_DIR_DOWN = 1'b1
  } tw_dir_t;
  // One bit per timer event, laid out as in flag and mask registers
  typedef struct packed {
    logic match_b;
    logic ovf;
    logic match_a;
  } tw_evt_t;
endpackage

// *** design/tw_timer8.sv ***
// 8-bit timer with two compare channels, waveform modes and APB registers
`timescale 1ns/1ps
`include "tw_params.svh"

module tw_timer8 (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Interrupt handshake with the core
  input  wire logic           global_irq_en,
  input  tw_pkg::tw_evt_t     vector_ack,
  output tw_pkg::tw_evt_t     irq_req,
  // Board pins
  input  wire logic           ext_count_pin,
  output logic                wave_out_a,
  output logic                wave_oe_a,
  output logic                wave_out_b,
  output logic                wave_oe_b
);

  // Software visible state
  logic [1:0]          out_action_a;     // Channel A action
  logic [1:0]          out_action_b;     // Channel B action
  logic [1:0]          wave_mode_low;    // Low mode bits
  logic                wave_mode_high;   // High mode bit
  logic [2:0]          clock_source_sel; // Clock select
  logic [7:0]          timer_count;      // Counter
  logic [7:0]          compare_value_a;  // Written compare A
  logic [7:0]          compare_value_b;  // Written compare B
  tw_pkg::tw_evt_t     timer_irq_flags;  // Sticky flags
  tw_pkg::tw_evt_t     timer_irq_mask;   // Enables
  // Internal state
  logic [7:0]          cmp_live_a;       // Compare A in use
  logic [7:0]          cmp_live_b;       // Compare B in use
  tw_pkg::tw_dir_t     dir;              // Count direction
  logic                block_match;      // Set by counter write
  logic [`TW_PRE_W-1:0] pre_cnt;         // Prescaler
  logic                pin_s1;           // Sync stage 1
  logic                pin_s2;           // Sync stage 2
  logic                pin_s3;           // Edge history

  // Address decode: aligned word at four times the index
  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    reg_hit = (a[11:10] == 2'b00) && (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // Prescaler tap: true on the last cycle of each division
  function automatic logic pre_tap(input logic [`TW_PRE_W-1:0] c,
                                   input logic [`TW_PRE_W-1:0] m);
    pre_tap = ((c & m) == m);
  endfunction

  // Next waveform level for one channel
  function automatic logic wave_next(
    input logic       cur,
    input logic [1:0] act,
    input logic       fast,
    input logic       pc,
    input logic       tog_ok,
    input logic       hit,
    input logic       bottom,
    input logic       down
  );
    wave_next = cur;
    if (!fast && !pc) begin
      // Non-PWM actions on a match or forced match
      if (hit) begin
        unique case (act)
          `TW_ACT_OFF: wave_next = cur;
          `TW_ACT_TOG: wave_next = ~cur;
          `TW_ACT_CLR: wave_next = 1'b0;
          `TW_ACT_SET: wave_next = 1'b1;
        endcase
      end
    end else if (act[1]) begin
      // Bottom wins so a compare equal to TOP acts at BOTTOM
      if (fast && bottom) begin
        wave_next = ~act[0];
      end else if (hit) begin
        wave_next = (pc && down) ? ~act[0] : act[0];
      end
    end else if (act == `TW_ACT_TOG && tog_ok && hit) begin
      wave_next = ~cur;
    end
  endfunction

  // Mode decode
  tw_pkg::tw_wave_mode_t mode;
  logic mode_pc;
  logic mode_fast;
  logic top_is_a;
  logic [7:0] top_val;
  always_comb begin
    mode      = tw_pkg::tw_wave_mode_t'({wave_mode_high, wave_mode_low});
    mode_pc   = (mode == tw_pkg::TW_WM_PC_MAX) || (mode == tw_pkg::TW_WM_PC_A);
    mode_fast = (mode == tw_pkg::TW_WM_FAST_MX) || (mode == tw_pkg::TW_WM_FAST_A);
    // Reserved codes 4 and 6 behave as normal mode
    top_is_a  = (mode == tw_pkg::TW_WM_CTC) || (mode == tw_pkg::TW_WM_PC_A)
             || (mode == tw_pkg::TW_WM_FAST_A);
    top_val   = top_is_a ? cmp_live_a : `TW_MAX;
  end

  // Bus strobes
  logic wr_en;
  logic rd_sel;
  always_comb begin
    wr_en  = psel && penable && pready && pwrite;
    rd_sel = psel && !penable;
  end

  // Timer clock select
  logic tick;
  logic pin_rise;
  logic pin_fall;
  always_comb begin
    // Edge detect reads only the settled stages
    pin_rise = pin_s2 && !pin_s3;
    pin_fall = !pin_s2 && pin_s3;
    unique case (clock_source_sel)
      3'b000:  tick = 1'b0;
      3'b001:  tick = 1'b1;
      3'b010:  tick = pre_tap(pre_cnt, `TW_DIV8);
      3'b011:  tick = pre_tap(pre_cnt, `TW_DIV64);
      3'b100:  tick = pre_tap(pre_cnt, `TW_DIV256);
      3'b101:  tick = pre_tap(pre_cnt, `TW_DIV1024);
      3'b110:  tick = pin_fall;
      3'b111:  tick = pin_rise;
    endcase
  end

  // Count events
  logic at_top;
  logic hit_a;
  logic hit_b;
  logic wrap;
  logic ovf_set;
  always_comb begin
    at_top = (timer_count == top_val);
    // Matches are suppressed on the tick after a counter write
    hit_a  = tick && !block_match && (timer_count == cmp_live_a);
    hit_b  = tick && !block_match && (timer_count == cmp_live_b);
    wrap   = tick && !mode_pc && at_top;
    unique case (mode)
      tw_pkg::TW_WM_PC_MAX, tw_pkg::TW_WM_PC_A:
        ovf_set = tick && (dir == tw_pkg::TW_DIR_DOWN) && (timer_count == `TW_BOTTOM);
      tw_pkg::TW_WM_FAST_A:
        ovf_set = tick && at_top;
      default:
        ovf_set = tick && (timer_count == `TW_MAX);
    endcase
  end

  // Force strobes, honoured only outside PWM modes
  logic force_a;
  logic force_b;
  always_comb begin
    force_a = wr_en && reg_hit(paddr, `TW_IDX_CTRL_B) && pwdata[`TW_CB_FORCE_A]
              && !mode_pc && !mode_fast;
    force_b = wr_en && reg_hit(paddr, `TW_IDX_CTRL_B) && pwdata[`TW_CB_FORCE_B]
              && !mode_pc && !mode_fast;
  end

  // Prescaler runs freely; taps are shared by all divisions
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= `TW_PRE_ZERO;
    end else begin
      pre_cnt <= pre_cnt + `TW_PRE_ONE;
    end
  end

  // Pin synchroniser; the pin is sampled whatever drives it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= ext_count_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_action_a     <= `TW_ACT_OFF;
      out_action_b     <= `TW_ACT_OFF;
      wave_mode_low    <= 2'b00;
      wave_mode_high   <= 1'b0;
      clock_source_sel <= 3'b000;
      timer_irq_mask   <= '0;
    end else if (wr_en) begin
      if (reg_hit(paddr, `TW_IDX_CTRL_A)) begin
        out_action_a  <= pwdata[`TW_CA_ACT_A];
        out_action_b  <= pwdata[`TW_CA_ACT_B];
        wave_mode_low <= pwdata[`TW_CA_WML];
      end
      if (reg_hit(paddr, `TW_IDX_CTRL_B)) begin
        // Force bits are not stored
        wave_mode_high   <= pwdata[`TW_CB_WMH];
        clock_source_sel <= pwdata[`TW_CB_CS];
      end
      if (reg_hit(paddr, `TW_IDX_MASK)) begin
        timer_irq_mask <= tw_pkg::tw_evt_t'(pwdata[2:0]);
      end
    end
  end

  // Written compare values
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_a <= `TW_RST8;
      compare_value_b <= `TW_RST8;
    end else if (wr_en) begin
      if (reg_hit(paddr, `TW_IDX_CMP_A)) begin
        compare_value_a <= pwdata[7:0];
      end
      if (reg_hit(paddr, `TW_IDX_CMP_B)) begin
        compare_value_b <= pwdata[7:0];
      end
    end
  end

  // Compare values in use: immediate, at TOP, or at BOTTOM
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_live_a <= `TW_RST8;
      cmp_live_b <= `TW_RST8;
    end else if (mode_pc) begin
      if (tick && at_top) begin
        cmp_live_a <= compare_value_a;
        cmp_live_b <= compare_value_b;
      end
    end else if (mode_fast) begin
      if (wrap) begin
        cmp_live_a <= compare_value_a;
        cmp_live_b <= compare_value_b;
      end
    end else begin
      // Follows the written value with one cycle of latency
      cmp_live_a <= compare_value_a;
      cmp_live_b <= compare_value_b;
    end
  end

  // Counter and direction; a bus write beats the tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= `TW_RST8;
      dir         <= tw_pkg::TW_DIR_UP;
    end else if (wr_en && reg_hit(paddr, `TW_IDX_COUNT)) begin
      timer_count <= pwdata[7:0];
    end else if (!mode_pc) begin
      dir <= tw_pkg::TW_DIR_UP;
      if (tick) begin
        // Forced matches never reach this clear
        timer_count <= at_top ? `TW_BOTTOM : timer_count + `TW_ONE;
      end
    end else if (tick) begin
      unique case (dir)
        tw_pkg::TW_DIR_UP: begin
          if (at_top) begin
            dir         <= tw_pkg::TW_DIR_DOWN;
            timer_count <= timer_count - `TW_ONE;
          end else begin
            timer_count <= timer_count + `TW_ONE;
          end
        end
        tw_pkg::TW_DIR_DOWN: begin
          if (timer_count == `TW_BOTTOM) begin
            dir         <= tw_pkg::TW_DIR_UP;
            timer_count <= timer_count + `TW_ONE;
          end else begin
            timer_count <= timer_count - `TW_ONE;
          end
        end
      endcase
    end
  end

  // Match suppression after a counter write lasts one timer tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      block_match <= 1'b0;
    end else if (wr_en && reg_hit(paddr, `TW_IDX_COUNT)) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  tw_pkg::tw_evt_t flag_set;
  tw_pkg::tw_evt_t flag_clr;
  always_comb begin
    // Force strobes are left out of the set terms
    flag_set.match_a = hit_a;
    flag_set.match_b = hit_b;
    flag_set.ovf     = ovf_set;
    flag_clr = vector_ack;
    if (wr_en && reg_hit(paddr, `TW_IDX_FLAGS)) begin
      flag_clr = flag_clr | tw_pkg::tw_evt_t'(pwdata[2:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq_flags <= '0;
    end else begin
      timer_irq_flags <= (timer_irq_flags & ~flag_clr) | flag_set;
    end
  end

  // Interrupt requests, registered so they come from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= timer_irq_flags & timer_irq_mask & {3{global_irq_en}};
    end
  end

  // Waveform outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      // Non-PWM hits include the forced strobe
      wave_out_a <= wave_next(wave_out_a, out_action_a, mode_fast, mode_pc,
                              wave_mode_high, hit_a || force_a, wrap,
                              dir == tw_pkg::TW_DIR_DOWN);
      wave_out_b <= wave_next(wave_out_b, out_action_b, mode_fast, mode_pc,
                              1'b0, hit_b || force_b, wrap,
                              dir == tw_pkg::TW_DIR_DOWN);
    end
  end

  // Pin ownership; toggle code in PWM needs the high mode bit on A only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wave_oe_a <= 1'b0;
      wave_oe_b <= 1'b0;
    end else begin
      wave_oe_a <= (out_action_a != `TW_ACT_OFF)
                && !((mode_pc || mode_fast) && out_action_a == `TW_ACT_TOG
                     && !wave_mode_high);
      wave_oe_b <= (out_action_b != `TW_ACT_OFF)
                && !((mode_pc || mode_fast) && out_action_b == `TW_ACT_TOG);
    end
  end

  // APB answer: data and ready staged in the setup cycle, zero wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_sel;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (rd_sel) begin
        if (reg_hit(paddr, `TW_IDX_FLAGS)) begin
          prdata[2:0] <= timer_irq_flags;
        end else if (reg_hit(paddr, `TW_IDX_MASK)) begin
          prdata[2:0] <= timer_irq_mask;
        end else if (reg_hit(paddr, `TW_IDX_CTRL_A)) begin
          prdata[7:0] <= {out_action_a, out_action_b, 2'b00, wave_mode_low};
        end else if (reg_hit(paddr, `TW_IDX_CTRL_B)) begin
          // Force and reserved bits read zero
          prdata[7:0] <= {4'h0, wave_mode_high, clock_source_sel};
        end else if (reg_hit(paddr, `TW_IDX_COUNT)) begin
          prdata[7:0] <= timer_count;
        end else if (reg_hit(paddr, `TW_IDX_CMP_A)) begin
          prdata[7:0] <= compare_value_a;
        end else if (reg_hit(paddr, `TW_IDX_CMP_B)) begin
          prdata[7:0] <= compare_value_b;
        end else begin
          // Unmapped address errors, writes there are dropped
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule

// *** test/tw_timer8_props.sv ***
// Port-level checker for the 8-bit waveform timer
`timescale 1ns/1ps
`include "tw_params.svh"
module tw_timer8_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt side
  input wire logic        global_irq_en,
  input tw_pkg::tw_evt_t  irq_req
);
  // Address hits one of the seven word registers
  logic mapped;
  assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                  (paddr[9:2] >= `TW_IDX_FLAGS) && (paddr[9:2] <= `TW_IDX_CMP_B);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (s_setup ##0 !mapped |=> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (s_setup ##0 mapped |=> !pslverr)
    else $error("error on mapped address");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside access");
  a_rdata_upper: assert property (s_done |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_force_reads_zero: assert property (
    s_done ##0 (!pwrite && mapped && paddr[9:2] == `TW_IDX_CTRL_B) |-> prdata[7:4] == 4'h0)
    else $error("strobe or reserved bits read nonzero");
  a_irq_needs_global: assert property (!global_irq_en |=> irq_req == 3'b000)
    else $error("request without global enable");
  a_irq_mask_off: assert property (
    s_done ##0 (pwrite && mapped && paddr[9:2] == `TW_IDX_MASK && pwdata[2:0] == 3'b000)
    |=> ##1 irq_req == 3'b000)
    else $error("request with all enables off");
endmodule
bind tw_timer8 tw_timer8_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en), .irq_req(irq_req));

// *** test/tb_top.sv ***
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
`include "tw_params.svh"
module tb_top;
  // Expected read result with its name
  typedef struct { string nm; logic [32:0] v; } tw_note_t;
  tw_note_t        notes[$];
  tw_note_t        n;
  int              error_cnt = 0;
  int              compares = 0;
  logic [7:0]      r;
  // Design inputs
  logic            clk_sys = 1'b0;
  logic            rst_n = 1'b0;
  logic            psel, penable, pwrite, global_irq_en, ext_count_pin;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  tw_pkg::tw_evt_t vector_ack;
  // Design outputs
  logic [31:0]     prdata;
  logic            pready, pslverr, wave_out_a, wave_oe_a, wave_out_b, wave_oe_b;
  tw_pkg::tw_evt_t irq_req;
  tw_timer8 u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_en(global_irq_en), .vector_ack(vector_ack),
    .irq_req(irq_req), .ext_count_pin(ext_count_pin), .wave_out_a(wave_out_a),
    .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b));
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  // Closing report
  task automatic give_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One comparison; four-state equality so unknowns fail
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read results are matched to the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      n = notes.pop_front();
      chk(n.nm, n.v, {pslverr, prdata});
    end
  end
  // One APB transfer; held until ready is seen, waits bounded
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
                      input string nm, input logic [32:0] e);
    int k;
    @(posedge clk_sys);
    if (!w) notes.push_back('{nm, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    xfer(1'b1, i, d, "", 33'h0);
  endtask
  task automatic rd(input string nm, input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0, nm, {1'b0, e});
  endtask
  // Pin pulses, slow enough for the two-flop synchroniser
  task automatic pulses(input int m);
    repeat (m) begin
      repeat (4) @(posedge clk_sys);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_count_pin <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, global_irq_en, ext_count_pin} = 5'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    vector_ack = 3'b000;
    void'($urandom(55));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, then an unmapped word
    for (int i = `TW_IDX_FLAGS; i <= `TW_IDX_CMP_B; i++) rd("reset", i[7:0], 32'h0);
    xfer(1'b0, 8'h40, 32'h0, "unmapped", {1'b1, 32'h0});
    wr(`TW_IDX_CTRL_B, 32'hf8);
    rd("control b", `TW_IDX_CTRL_B, 32'h08);
    wr(`TW_IDX_CTRL_B, 32'h00);
    // Random values with the counter stopped
    repeat (4) begin
      r = 8'($urandom());
      wr(`TW_IDX_CMP_A, {24'h0, r});
      wr(`TW_IDX_CMP_B, {24'h0, ~r});
      wr(`TW_IDX_COUNT, {24'h0, r + 8'h01});
      rd("compare a", `TW_IDX_CMP_A, {24'h0, r});
      rd("compare b", `TW_IDX_CMP_B, {24'h0, ~r});
      rd("count", `TW_IDX_COUNT, {24'h0, r + 8'h01});
    end
    // Normal mode run across both matches and the wrap
    wr(`TW_IDX_COUNT, 32'hf0);
    wr(`TW_IDX_CMP_A, 32'hf4);
    wr(`TW_IDX_CMP_B, 32'h03);
    wr(`TW_IDX_MASK, 32'h07);
    global_irq_en <= 1'b1;
    wr(`TW_IDX_CTRL_B, 32'h01);
    for (int k = 0; k < 400 && irq_req !== 3'b111; k++) @(posedge clk_sys);
    chk("requests", 33'h7, 33'(irq_req));
    // A run that never raised all requests has timed out
    if (irq_req !== 3'b111) give_verdict();
    wr(`TW_IDX_CTRL_B, 32'h00);
    rd("flags after run", `TW_IDX_FLAGS, 32'h07);
    global_irq_en <= 1'b0;
    @(posedge clk_sys);
    #1 chk("gated requests", 33'h0, 33'(irq_req));
    @(posedge clk_sys);
    global_irq_en <= 1'b1;
    vector_ack <= 3'b010;
    @(posedge clk_sys);
    vector_ack <= 3'b000;
    rd("flags after ack", `TW_IDX_FLAGS, 32'h05);
    chk("requests after ack", 33'h5, 33'(irq_req));
    wr(`TW_IDX_FLAGS, 32'h01);
    rd("flags after a clear", `TW_IDX_FLAGS, 32'h04);
    wr(`TW_IDX_FLAGS, 32'h04);
    rd("flags after b clear", `TW_IDX_FLAGS, 32'h00);
    wr(`TW_IDX_MASK, 32'h00);
    // Forced matches: toggle and set, then clear
    wr(`TW_IDX_CTRL_A, 32'h70);
    wr(`TW_IDX_CTRL_B, 32'hc0);
    #1 chk("forced outputs", 33'hf, {29'h0, wave_oe_a, wave_oe_b, wave_out_a, wave_out_b});
    wr(`TW_IDX_COUNT, 32'h33);
    wr(`TW_IDX_CMP_A, 32'h33);
    wr(`TW_IDX_CTRL_A, 32'h42);
    wr(`TW_IDX_CTRL_B, 32'h80);
    #1 chk("forced toggle", 33'h0, {32'h0, wave_out_a});
    rd("count after force", `TW_IDX_COUNT, 32'h33);
    rd("flags after force", `TW_IDX_FLAGS, 32'h00);
    wr(`TW_IDX_CTRL_A, 32'ha0);
    wr(`TW_IDX_CTRL_B, 32'hc0);
    #1 chk("forced clear", 33'h0, {31'h0, wave_out_a, wave_out_b});
    // Counting from the pin, rising then falling edges
    wr(`TW_IDX_CTRL_A, 32'h00);
    wr(`TW_IDX_COUNT, 32'h00);
    wr(`TW_IDX_CTRL_B, 32'h07);
    pulses(3);
    rd("rising edge count", `TW_IDX_COUNT, 32'h03);
    wr(`TW_IDX_CTRL_B, 32'h06);
    pulses(2);
    rd("falling edge count", `TW_IDX_COUNT, 32'h05);
    // Prescaled counts; any window of ten divisions holds ten ticks
    for (int s = 0; s < 2; s++) begin
      wr(`TW_IDX_COUNT, 32'h00);
      wr(`TW_IDX_CTRL_B, {29'h0, 3'(s + 2)});
      repeat (s ? 637 : 77) @(posedge clk_sys);
      wr(`TW_IDX_CTRL_B, 32'h00);
      rd("prescaled count", `TW_IDX_COUNT, 32'h0a);
    end
    // Fast PWM with compare A as TOP; force bits kept zero
    wr(`TW_IDX_CMP_A, 32'h0f);
    wr(`TW_IDX_CMP_B, 32'h05);
    wr(`TW_IDX_COUNT, 32'h00);
    wr(`TW_IDX_FLAGS, 32'h07);
    wr(`TW_IDX_CTRL_A, 32'h23);
    wr(`TW_IDX_CTRL_B, 32'h09);
    repeat (32) @(posedge clk_sys);
    wr(`TW_IDX_CTRL_B, 32'h08);
    rd("fast count", `TW_IDX_COUNT, 32'h03);
    rd("fast flags", `TW_IDX_FLAGS, 32'h07);
    chk("fast pins", 33'h3, {30'h0, wave_oe_a, wave_oe_b, wave_out_b});
    // New compare B waits for BOTTOM, so the old match still clears
    wr(`TW_IDX_CMP_B, 32'h02);
    wr(`TW_IDX_CTRL_B, 32'h09);
    wr(`TW_IDX_CTRL_B, 32'h08);
    rd("fast restart count", `TW_IDX_COUNT, 32'h06);
    chk("buffered compare", 33'h0, {32'h0, wave_out_b});
    // Phase-correct with compare A as TOP, stopped while counting down
    wr(`TW_IDX_COUNT, 32'h00);
    wr(`TW_IDX_FLAGS, 32'h07);
    wr(`TW_IDX_CTRL_A, 32'h21);
    wr(`TW_IDX_CTRL_B, 32'h09);
    repeat (17) @(posedge clk_sys);
    wr(`TW_IDX_CTRL_B, 32'h08);
    rd("phase count", `TW_IDX_COUNT, 32'h0a);
    rd("phase flags", `TW_IDX_FLAGS, 32'h05);
    repeat (3) @(posedge clk_sys);
    give_verdict();
  end
endmodule
